// ---- src/cia_core_irq_addr.sv ----
`include "cia_defines.svh"

module cia_core_irq_addr (
	// Clock, reset and enable
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	// Peripheral requests, one-cycle pulses
	input  wire logic                wakeup_edge_irq,
	input  wire logic                first_timer_irq,
	input  wire logic                second_timer_irq,
	// Sequencer handshake
	input  wire logic                instr_done,
	input  wire cia_pkg::cia_kind_t  instr_kind,
	input  wire logic [9:0]          pc,
	output logic                     core_hold,
	output logic                     pc_load,
	output logic [9:0]               pc_new_r,
	// Memory port
	output logic                     mem_rd_en,
	output logic                     mem_wr_en,
	output logic [11:0]              mem_addr,
	output logic [7:0]               mem_wdata,
	input  wire logic [7:0]          mem_rdata,
	// Status
	output logic                     irq_enable_r,
	output logic [3:0]               sp_r,
	output logic [3:0]               pending_r,
	output logic [2:0]               service_level_r,
	// Address generation
	input  wire logic                addr_req,
	input  wire cia_pkg::cia_group_t addr_group,
	input  wire cia_pkg::cia_mode_t  addr_mode,
	input  wire logic [10:0]         index_ptr,
	input  wire logic [7:0]          opnd_byte0,
	input  wire logic [7:0]          opnd_byte1,
	output logic                     addr_valid_r,
	output logic [11:0]              eff_addr_r,
	output logic [7:0]               operand_r,
	output logic [9:0]               target_pc_r,
	output logic [1:0]               opnd_bytes_r,
	output logic                     mode_err_r
);
	import cia_pkg::*;

	// ****************************************************************
	// Interrupt state
	// ****************************************************************
	cia_state_t  state_r;
	cia_state_t  state_nxt;
	logic [3:0]  req_set;
	logic [3:0]  eligible;
	logic [3:0]  grant;
	logic [1:0]  sel_r;
	logic [9:0]  ret_pc_r;
	logic [7:0]  vec_lo_r;
	logic [11:0] vec_base;
	logic        boundary;
	logic        start_entry;
	logic        start_return_from_irq_instr;

	assign boundary = ce && instr_done && (state_r == CIA_IDLE);

	assign req_set[`CIA_SRC_TRAP] = boundary &&
		(instr_kind == CIA_KIND_TRAP);
	assign req_set[`CIA_SRC_TMR1] = second_timer_irq;
	assign req_set[`CIA_SRC_TMR0] = first_timer_irq;
	assign req_set[`CIA_SRC_WAKE] = wakeup_edge_irq;

	// The trap is never masked; the three peripherals need the enable.
	assign eligible = pending_r &
		{irq_enable_r, irq_enable_r, irq_enable_r, 1'b1};

	// Highest index wins, so wakeup outranks both timers and the trap.
	always_comb begin
		grant = 4'h0;
		if (eligible[`CIA_SRC_WAKE]) begin
			grant[`CIA_SRC_WAKE] = 1'b1;
		end else if (eligible[`CIA_SRC_TMR0]) begin
			grant[`CIA_SRC_TMR0] = 1'b1;
		end else if (eligible[`CIA_SRC_TMR1]) begin
			grant[`CIA_SRC_TMR1] = 1'b1;
		end else if (eligible[`CIA_SRC_TRAP]) begin
			grant[`CIA_SRC_TRAP] = 1'b1;
		end
	end

	// A trap instruction completing now must enter even though its
	// pending bit is only being set this very cycle.
	assign start_return_from_irq_instr  = boundary && (instr_kind == CIA_KIND_RETURN_FROM_IRQ_INSTR);
	assign start_entry = boundary && !start_return_from_irq_instr &&
		((|eligible) || req_set[`CIA_SRC_TRAP]);

	// ****************************************************************
	// Pending latches
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < `CIA_NUM_SRC; gi++) begin : g_pend
			// Set wins over the service clear so no edge is lost.
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					pending_r[gi] <= 1'b0;
				end else if (ce) begin
					if (req_set[gi]) begin
						pending_r[gi] <= 1'b1;
					end else if (state_r == CIA_GO &&
						sel_r == 2'(gi)) begin
						pending_r[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CIA_IDLE: begin
				if (start_return_from_irq_instr) begin
					state_nxt = CIA_POP_HI;
				end else if (start_entry) begin
					state_nxt = CIA_PUSH_LO;
				end
			end
			CIA_PUSH_LO: state_nxt = CIA_PUSH_HI;
			CIA_PUSH_HI: state_nxt = CIA_VEC_LO;
			CIA_VEC_LO:  state_nxt = CIA_VEC_HI;
			CIA_VEC_HI:  state_nxt = CIA_GO;
			CIA_GO:      state_nxt = CIA_IDLE;
			CIA_POP_HI:  state_nxt = CIA_POP_LO;
			CIA_POP_LO:  state_nxt = CIA_IDLE;
			default:     state_nxt = CIA_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CIA_IDLE;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// Source choice and return address are frozen at the boundary.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_r    <= 2'h0;
			ret_pc_r <= 10'h000;
		end else if (ce && start_entry) begin
			ret_pc_r <= pc;
			if (|eligible) begin
				sel_r <= grant[3] ? 2'h3 : grant[2] ? 2'h2 :
					grant[1] ? 2'h1 : 2'h0;
			end else begin
				sel_r <= 2'(`CIA_SRC_TRAP);
			end
		end
	end

	always_comb begin
		case (sel_r)
			2'h3:    vec_base = `CIA_VEC_WAKE;
			2'h2:    vec_base = `CIA_VEC_TMR0;
			2'h1:    vec_base = `CIA_VEC_TMR1;
			default: vec_base = `CIA_VEC_TRAP;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			service_level_r <= 3'h0;
		end else if (ce && state_r == CIA_GO) begin
			service_level_r <= 3'(sel_r) + 3'h1;
		end
	end

	// ****************************************************************
	// Stack pointer and memory port
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_r <= `CIA_SP_RESET;
		end else if (ce) begin
			if (state_r == CIA_PUSH_HI) begin
				sp_r <= sp_r - `CIA_SP_STEP;
			end else if (state_r == CIA_POP_LO) begin
				sp_r <= sp_r + `CIA_SP_STEP;
			end
		end
	end

	// Reads are taken combinationally from mem_rdata in the same cycle.
	always_comb begin
		mem_rd_en = 1'b0;
		mem_wr_en = 1'b0;
		mem_addr  = 12'h000;
		mem_wdata = 8'h00;
		case (state_r)
			CIA_PUSH_LO: begin
				mem_wr_en = 1'b1;
				mem_addr  = {4'h0, `CIA_STACK_BASE | {4'h0, sp_r}};
				mem_wdata = ret_pc_r[7:0];
			end
			CIA_PUSH_HI: begin
				mem_wr_en = 1'b1;
				mem_addr  = {4'h0, `CIA_STACK_BASE |
					{4'h0, 4'(sp_r - 4'h1)}};
				mem_wdata = {6'h00, ret_pc_r[9:8]};
			end
			CIA_VEC_LO: begin
				mem_rd_en = 1'b1;
				mem_addr  = vec_base;
			end
			CIA_VEC_HI: begin
				mem_rd_en = 1'b1;
				mem_addr  = vec_base + 12'h001;
			end
			CIA_POP_HI: begin
				mem_rd_en = 1'b1;
				mem_addr  = {4'h0, `CIA_STACK_BASE |
					{4'h0, 4'(sp_r + 4'h1)}};
			end
			CIA_POP_LO: begin
				mem_rd_en = 1'b1;
				mem_addr  = {4'h0, `CIA_STACK_BASE |
					{4'h0, 4'(sp_r + `CIA_SP_STEP)}};
			end
			default: begin
				mem_rd_en = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Program counter reload
	// ****************************************************************
	logic [1:0] pop_hi_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_lo_r <= 8'h00;
			pop_hi_r <= 2'h0;
			pc_new_r <= 10'h000;
		end else if (ce) begin
			case (state_r)
				CIA_VEC_LO: vec_lo_r <= mem_rdata;
				CIA_VEC_HI: pc_new_r <= {mem_rdata[1:0], vec_lo_r};
				CIA_POP_HI: pop_hi_r <= mem_rdata[1:0];
				CIA_POP_LO: pc_new_r <= {pop_hi_r, mem_rdata};
				default:    pc_new_r <= pc_new_r;
			endcase
		end
	end

	// The hold covers the whole entry so the fifth cycle is the load.
	assign core_hold = (state_r != CIA_IDLE);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_load <= 1'b0;
		end else if (ce) begin
			pc_load <= (state_r == CIA_VEC_HI) ||
				(state_r == CIA_POP_LO);
		end
	end

	// ****************************************************************
	// Global enable
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_r <= `CIA_G_RESET;
		end else if (ce) begin
			if (state_r == CIA_GO) begin
				irq_enable_r <= 1'b0;
			end else if (state_r == CIA_POP_LO) begin
				irq_enable_r <= 1'b1;
			end else if (boundary &&
				instr_kind == CIA_KIND_SET_G) begin
				irq_enable_r <= 1'b1;
			end else if (boundary &&
				instr_kind == CIA_KIND_CLR_G) begin
				irq_enable_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Operand address generation
	// ****************************************************************
	function automatic logic [6:0] cia_legal(input cia_group_t grp);
		logic [6:0] m;
		m = 7'h00;
		case (grp)
			CIA_GRP_ALU:    m = 7'b0001011;
			CIA_GRP_CMP:    m = 7'b0001011;
			CIA_GRP_RMW:    m = 7'b0011010;
			CIA_GRP_LD:     m = 7'b0001111;
			CIA_GRP_ST:     m = 7'b0001110;
			CIA_GRP_BIT:    m = 7'b0001011;
			CIA_GRP_CARRY:  m = 7'b0000010;
			CIA_GRP_ROT:    m = 7'b0010010;
			CIA_GRP_INH:    m = 7'b0010000;
			CIA_GRP_JSHORT: m = 7'b0100000;
			CIA_GRP_JLONG:  m = 7'b1000000;
			default:        m = 7'h00;
		endcase
		return m;
	endfunction : cia_legal

	logic [9:0]        idx_sum;
	logic [1:0]        space;
	logic signed [8:0] rel_disp;
	logic              legal;

	assign idx_sum  = index_ptr[9:0] + {2'h0, opnd_byte0};
	assign space    = index_ptr[10] ? `CIA_PROG_SPACE : `CIA_DATA_SPACE;
	assign rel_disp = {opnd_byte0[7], opnd_byte0};
	assign legal    = |(cia_legal(addr_group) &
		(7'h01 << addr_mode));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_valid_r <= 1'b0;
			eff_addr_r   <= 12'h000;
			operand_r    <= 8'h00;
			target_pc_r  <= 10'h000;
			opnd_bytes_r <= 2'h0;
			mode_err_r   <= 1'b0;
		end else if (ce) begin
			addr_valid_r <= addr_req;
			if (addr_req) begin
				mode_err_r   <= !legal;
				eff_addr_r   <= 12'h000;
				operand_r    <= 8'h00;
				target_pc_r  <= pc;
				opnd_bytes_r <= 2'h1;
				case (addr_mode)
					CIA_AM_IDX: begin
						eff_addr_r <= {space, idx_sum};
					end
					CIA_AM_IND: begin
						eff_addr_r   <= {space, index_ptr[9:0]};
						opnd_bytes_r <= 2'h0;
					end
					CIA_AM_DIR: begin
						eff_addr_r <= {4'h0, opnd_byte0};
					end
					CIA_AM_IMM: begin
						operand_r <= opnd_byte0;
					end
					CIA_AM_INH: begin
						opnd_bytes_r <= 2'h0;
					end
					CIA_AM_ABS: begin
						target_pc_r  <= {opnd_byte0[1:0], opnd_byte1};
						opnd_bytes_r <= 2'h2;
					end
					CIA_AM_REL: begin
						target_pc_r  <= 10'(pc + 10'(rel_disp));
						opnd_bytes_r <= 2'h0;
						if (rel_disp < 9'(`CIA_REL_MIN) ||
							rel_disp > 9'(`CIA_REL_MAX)) begin
							mode_err_r <= 1'b1;
						end
					end
					default: begin
						mode_err_r <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule : cia_core_irq_addr

// ---- src/cia_defines.svh ----
`ifndef CIA_DEFINES_SVH
`define CIA_DEFINES_SVH

// ****************************************************************
// Interrupt constants
// ****************************************************************
`define CIA_NUM_SRC        4
`define CIA_SRC_TRAP       0
`define CIA_SRC_TMR1       1
`define CIA_SRC_TMR0       2
`define CIA_SRC_WAKE       3
`define CIA_ENTRY_CYCLES   5
`define CIA_G_RESET        1'b0
`define CIA_VEC_TMR0       12'hff6
`define CIA_VEC_TMR1       12'hff8
`define CIA_VEC_WAKE       12'hffa
`define CIA_VEC_TRAP       12'hffc

// ****************************************************************
// Stack constants
// ****************************************************************
`define CIA_SP_RESET       4'hf
`define CIA_SP_STEP        4'h2
`define CIA_STACK_BASE     8'h30

// ****************************************************************
// Addressing constants
// ****************************************************************
`define CIA_PROG_SPACE     2'h3
`define CIA_DATA_SPACE     2'h0
`define CIA_REL_MIN        (-31)
`define CIA_REL_MAX        32

`endif

// ---- src/cia_pkg.sv ----
package cia_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		CIA_IDLE    = 3'h0,
		CIA_PUSH_LO = 3'h1,
		CIA_PUSH_HI = 3'h3,
		CIA_VEC_LO  = 3'h2,
		CIA_VEC_HI  = 3'h6,
		CIA_GO      = 3'h7,
		CIA_POP_HI  = 3'h5,
		CIA_POP_LO  = 3'h4
	} cia_state_t;

	typedef enum logic [2:0] {
		CIA_KIND_PLAIN = 3'h0,
		CIA_KIND_SET_G = 3'h1,
		CIA_KIND_CLR_G = 3'h2,
		CIA_KIND_TRAP  = 3'h3,
		CIA_KIND_RETURN_FROM_IRQ_INSTR  = 3'h4
	} cia_kind_t;

	typedef enum logic [2:0] {
		CIA_AM_IMM = 3'h0,
		CIA_AM_DIR = 3'h1,
		CIA_AM_IDX = 3'h2,
		CIA_AM_IND = 3'h3,
		CIA_AM_INH = 3'h4,
		CIA_AM_REL = 3'h5,
		CIA_AM_ABS = 3'h6
	} cia_mode_t;

	typedef enum logic [3:0] {
		CIA_GRP_ALU    = 4'h0,
		CIA_GRP_RMW    = 4'h1,
		CIA_GRP_CMP    = 4'h2,
		CIA_GRP_LD     = 4'h3,
		CIA_GRP_ST     = 4'h4,
		CIA_GRP_BIT    = 4'h5,
		CIA_GRP_CARRY  = 4'h6,
		CIA_GRP_ROT    = 4'h7,
		CIA_GRP_INH    = 4'h8,
		CIA_GRP_JSHORT = 4'h9,
		CIA_GRP_JLONG  = 4'ha
	} cia_group_t;

endpackage : cia_pkg

// ---- tb/cia_irq_props.sv ----
module cia_irq_props (
	// Clock and reset
	input wire logic		core_clk,
	input wire logic		rst_n,
	// Sequencer
	input wire logic		instr_done,
	input wire cia_pkg::cia_kind_t	instr_kind,
	input wire logic		core_hold,
	input wire logic		pc_load,
	// Memory port
	input wire logic		mem_rd_en,
	input wire logic		mem_wr_en,
	input wire logic [11:0]		mem_addr,
	// Status
	input wire logic		irq_enable_r,
	input wire logic [3:0]		sp_r,
	input wire logic [3:0]		pending_r,
	// Address generation
	input wire logic		addr_req,
	input wire cia_pkg::cia_mode_t	addr_mode,
	input wire logic [10:0]		index_ptr,
	input wire logic [7:0]		opnd_byte0,
	input wire logic		addr_valid_r,
	input wire logic [11:0]		eff_addr_r,
	input wire logic [7:0]		operand_r
);
	timeunit 1ns;
	timeprecision 1ps;
	import cia_pkg::*;

	// ****
	// Properties
	// ****
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_g_reset;
		$rose(rst_n) |-> !irq_enable_r;
	endproperty
	a_g_reset: assert property (p_g_reset)
		else $error("enable set after reset");
	property p_entry;
		$rose(mem_wr_en) |-> core_hold[*4] ##1 pc_load && core_hold
			##1 !core_hold;
	endproperty
	a_entry: assert property (p_entry)
		else $error("entry length wrong");
	property p_push;
		$rose(mem_wr_en) |-> mem_addr == {8'h03, sp_r}
			##1 mem_wr_en && mem_addr == {8'h03, sp_r - 4'h1};
	endproperty
	a_push: assert property (p_push)
		else $error("push order wrong");
	property p_sp;
		$rose(mem_wr_en) |-> ##3 sp_r == $past(sp_r, 3) - 4'h2;
	endproperty
	a_sp: assert property (p_sp)
		else $error("stack pointer step wrong");
	property p_g_clr;
		$rose(mem_wr_en) |-> ##1 $stable(irq_enable_r)[*4]
			##1 !irq_enable_r;
	endproperty
	a_g_clr: assert property (p_g_clr)
		else $error("enable clear timing wrong");
	property p_pop;
		$rose(mem_rd_en) && mem_addr[11:4] == 8'h03
			|-> mem_addr[3:0] == sp_r + 4'h1
			##1 mem_rd_en && mem_addr[3:0] == sp_r + 4'h2
			##1 pc_load && irq_enable_r;
	endproperty
	a_pop: assert property (p_pop)
		else $error("return sequence wrong");
	property p_masked;
		instr_done && !core_hold && !irq_enable_r && !pending_r[0]
			&& instr_kind == CIA_KIND_PLAIN |=> !core_hold;
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked request entered");
	property p_trap;
		instr_done && !core_hold && instr_kind == CIA_KIND_TRAP
			|=> mem_wr_en;
	endproperty
	a_trap: assert property (p_trap)
		else $error("trap not entered");
	property p_imm;
		addr_req && addr_mode == CIA_AM_IMM
			|=> addr_valid_r && operand_r == $past(opnd_byte0);
	endproperty
	a_imm: assert property (p_imm)
		else $error("immediate operand wrong");
	property p_dir;
		addr_req && addr_mode == CIA_AM_DIR
			|=> eff_addr_r == {4'h0, $past(opnd_byte0)};
	endproperty
	a_dir: assert property (p_dir)
		else $error("direct address wrong");
	property p_idx;
		addr_req && addr_mode == CIA_AM_IDX |=> eff_addr_r[9:0]
			== $past(index_ptr[9:0]) + $past(opnd_byte0);
	endproperty
	a_idx: assert property (p_idx)
		else $error("indexed address wrong");
endmodule : cia_irq_props

bind cia_core_irq_addr cia_irq_props u_props (
	.core_clk, .rst_n, .instr_done, .instr_kind, .core_hold, .pc_load,
	.mem_rd_en, .mem_wr_en, .mem_addr, .irq_enable_r, .sp_r, .pending_r,
	.addr_req, .addr_mode, .index_ptr, .opnd_byte0, .addr_valid_r,
	.eff_addr_r, .operand_r
);

// ---- tb/cia_periph_model.sv ----
module cia_periph_model (
	// Clock, reset and command
	input wire logic		core_clk,
	input wire logic		rst_n,
	input wire logic [2:0]		fire,
	// Request pulses
	output logic			wakeup_edge_irq,
	output logic			first_timer_irq,
	output logic			second_timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pulses last one clock, so the core must latch them itself.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{wakeup_edge_irq, first_timer_irq, second_timer_irq} <= 3'h0;
		end else begin
			{wakeup_edge_irq, first_timer_irq, second_timer_irq} <= fire;
		end
	end
endmodule : cia_periph_model

// ---- tb/cia_core_irq_addr_tb.sv ----
module cia_core_irq_addr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cia_pkg::*;

	// ****
	// Signals
	// ****
	logic		core_clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		ce = 1'b1;
	logic [2:0]	fire = 3'h0;
	logic		instr_done = 1'b0;
	cia_kind_t	instr_kind = CIA_KIND_PLAIN;
	logic [9:0]	pc = 10'h0;
	logic		addr_req = 1'b0;
	cia_group_t	addr_group = CIA_GRP_ALU;
	cia_mode_t	addr_mode = CIA_AM_IMM;
	logic [10:0]	index_ptr = 11'h0;
	logic [7:0]	opnd_byte0 = 8'h0, opnd_byte1 = 8'h0, mem_rdata;
	logic		wakeup_edge_irq, first_timer_irq, second_timer_irq;
	logic		core_hold, pc_load, mem_rd_en, mem_wr_en, irq_enable_r;
	logic		addr_valid_r, mode_err_r;
	logic [9:0]	pc_new_r, target_pc_r;
	logic [11:0]	mem_addr, eff_addr_r;
	logic [7:0]	mem_wdata, operand_r;
	logic [3:0]	sp_r, pending_r;
	logic [2:0]	service_level_r;
	logic [1:0]	opnd_bytes_r;
	logic [7:0]	mem [0:4095];
	int		mismatches = 0, n_checks = 0;

	always #50 core_clk = ~core_clk;
	// Idle read data wanders so a stale byte is never taken for a good one.
	assign mem_rdata = mem_rd_en ? mem[mem_addr] : ~mem_addr[7:0];
	always @(posedge core_clk) if (mem_wr_en) mem[mem_addr] <= mem_wdata;

	cia_core_irq_addr dut (.core_clk, .rst_n, .ce, .wakeup_edge_irq,
		.first_timer_irq, .second_timer_irq, .instr_done, .instr_kind, .pc,
		.core_hold, .pc_load, .pc_new_r, .mem_rd_en, .mem_wr_en, .mem_addr,
		.mem_wdata, .mem_rdata, .irq_enable_r, .sp_r, .pending_r,
		.service_level_r, .addr_req, .addr_group, .addr_mode, .index_ptr,
		.opnd_byte0, .opnd_byte1, .addr_valid_r, .eff_addr_r, .operand_r,
		.target_pc_r, .opnd_bytes_r, .mode_err_r);
	cia_periph_model u_periph (.core_clk, .rst_n, .fire, .wakeup_edge_irq,
		.first_timer_irq, .second_timer_irq);

	// ****
	// Tasks
	// ****
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	task automatic step(input cia_kind_t k, input logic [9:0] p);
		@(negedge core_clk);
		instr_done = 1'b1;
		instr_kind = k;
		pc = p;
		@(negedge core_clk);
		instr_done = 1'b0;
	endtask : step

	task automatic wait_load(output int n);
		n = 1;
		while (pc_load !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
	endtask : wait_load

	task automatic entry(input cia_kind_t k, input logic [9:0] p,
			input logic [11:0] v, input logic [2:0] lvl);
		logic [3:0] s;
		int n;
		s = sp_r;
		step(k, p);
		wait_load(n);
		chk(n, 5);
		chk(pc_new_r, 10'h310 | v[3:0]);
		@(negedge core_clk);
		chk(irq_enable_r, 1'b0);
		chk(service_level_r, lvl);
		chk(sp_r, s - 4'h2);
		chk(mem[{8'h03, s}], p[7:0]);
		chk(mem[{8'h03, s - 4'h1}] & 8'h03, p[9:8]);
	endtask : entry

	task automatic return_from_irq_instr(input logic [9:0] p);
		logic [3:0] s;
		int n;
		s = sp_r;
		step(CIA_KIND_RETURN_FROM_IRQ_INSTR, 10'h0);
		wait_load(n);
		chk(n, 3);
		chk(pc_new_r, p);
		chk(irq_enable_r, 1'b1);
		chk(sp_r, s + 4'h2);
	endtask : return_from_irq_instr

	task automatic areq(input cia_group_t g, input cia_mode_t m,
			input logic [10:0] x, input logic [7:0] b0, b1);
		@(negedge core_clk);
		addr_req = 1'b1;
		addr_group = g;
		addr_mode = m;
		index_ptr = x;
		opnd_byte0 = b0;
		opnd_byte1 = b1;
		@(negedge core_clk);
		addr_req = 1'b0;
		chk(addr_valid_r, 1'b1);
	endtask : areq

	task automatic t_irq();
		fire = 3'h7;
		@(negedge core_clk);
		fire = 3'h0;
		step(CIA_KIND_PLAIN, 10'h055);
		chk(core_hold, 1'b0);
		chk(pending_r, 4'he);
		step(CIA_KIND_SET_G, 10'h056);
		entry(CIA_KIND_PLAIN, 10'h123, 12'hffa, 3'h4);
		step(CIA_KIND_SET_G, 10'h31b);
		entry(CIA_KIND_PLAIN, 10'h2a5, 12'hff6, 3'h3);
		return_from_irq_instr(10'h2a5);
		entry(CIA_KIND_PLAIN, 10'h0f0, 12'hff8, 3'h2);
		return_from_irq_instr(10'h0f0);
		return_from_irq_instr(10'h123);
		chk(pending_r, 4'h0);
	endtask : t_irq

	task automatic t_trap();
		step(CIA_KIND_CLR_G, 10'h200);
		entry(CIA_KIND_TRAP, 10'h3c1, 12'hffc, 3'h1);
		return_from_irq_instr(10'h3c1);
	endtask : t_trap

	task automatic t_addr();
		pc = 10'h100;
		areq(CIA_GRP_LD, CIA_AM_IMM, 11'h0, 8'ha5, 8'h0);
		chk({opnd_bytes_r, operand_r}, 10'h1a5);
		areq(CIA_GRP_ALU, CIA_AM_DIR, 11'h0, 8'h7e, 8'h0);
		chk(eff_addr_r, 12'h07e);
		areq(CIA_GRP_LD, CIA_AM_IDX, 11'h7f0, 8'h20, 8'h0);
		chk(eff_addr_r, 12'hc10);
		areq(CIA_GRP_ST, CIA_AM_IND, 11'h0c5, 8'h0, 8'h0);
		chk(eff_addr_r, 12'h0c5);
		areq(CIA_GRP_INH, CIA_AM_INH, 11'h0, 8'h0, 8'h0);
		chk({mode_err_r, opnd_bytes_r}, 3'h0);
		areq(CIA_GRP_JSHORT, CIA_AM_REL, 11'h0, 8'h20, 8'h0);
		chk({mode_err_r, target_pc_r}, 11'h120);
		areq(CIA_GRP_JSHORT, CIA_AM_REL, 11'h0, 8'he1, 8'h0);
		chk({mode_err_r, target_pc_r}, 11'h0e1);
		areq(CIA_GRP_JSHORT, CIA_AM_REL, 11'h0, 8'h21, 8'h0);
		chk(mode_err_r, 1'b1);
		areq(CIA_GRP_JLONG, CIA_AM_ABS, 11'h0, 8'h02, 8'h9c);
		chk({opnd_bytes_r, target_pc_r}, 12'ha9c);
		areq(CIA_GRP_JLONG, CIA_AM_IMM, 11'h0, 8'h11, 8'h0);
		chk(mode_err_r, 1'b1);
	endtask : t_addr

	task automatic t_reset2();
		ce = 1'b0;
		step(CIA_KIND_CLR_G, 10'h0);
		chk(irq_enable_r, 1'b1);
		ce = 1'b1;
		step(CIA_KIND_SET_G, 10'h0);
		chk(irq_enable_r, 1'b1);
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		chk(irq_enable_r, 1'b0);
		chk(sp_r, 4'hf);
	endtask : t_reset2

	// ****
	// Sequence
	// ****
	initial begin
		for (int i = 6; i < 14; i += 2) begin
			mem[12'hff0 + i] = 8'(16 + i);
			mem[12'hff1 + i] = 8'h03;
		end
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		chk({irq_enable_r, sp_r, pending_r}, 9'h0f0);
		t_irq();
		t_trap();
		t_addr();
		t_reset2();
		end_of_test();
	end

	initial begin
		#(100 * 5000);
		mismatches++;
		end_of_test();
	end
endmodule : cia_core_irq_addr_tb
